// ---- include/logic_fault_pkg.sv ----
// Constants shared by the logic fault status inquiry block
package logic_fault_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] BLOCK_BASE          = 16'h0C10;
  localparam logic [15:0] IDX_AVAILABILITY    = 16'h0000;
  localparam logic [15:0] IDX_ERROR_FLAGS     = 16'h0001;
  localparam logic [15:0] IDX_CONTROL         = 16'h0002;
  localparam logic [15:0] IDX_IRQ_STATUS      = 16'h0003;
  localparam logic [15:0] IDX_IRQ_MASK        = 16'h0004;

  // ----------------------------------------------------------------
  // Field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  AVAIL_ABSENT        = 8'h00;
  localparam logic [7:0]  AVAIL_PRESENT       = 8'h01;
  localparam int          FLAG_NO_FIRMWARE    = 0;
  localparam int          FLAG_LOAD_FAILED    = 1;
  localparam int          FLAG_RATE_EXCEEDED  = 2;
  localparam int          FLAG_NO_TRIGGER     = 3;
  localparam int          FLAG_RESERVED_TOP   = 7;
  localparam int          NUM_FLAGS           = 4;
  localparam int          CTRL_PROG_MODE      = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_CONTROL       = 8'h00;
  localparam logic [7:0]  RESET_IRQ_MASK      = 8'h00;
  localparam logic [7:0]  RESET_FLAGS         = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          MIN_LINE_PERIOD_NS  = 1000;
  localparam int          MIN_LINE_CYCLES     =
    (MIN_LINE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TRIGGER_TIMEOUT_US  = 10000;
  localparam int          TRIGGER_TIMEOUT_CYCLES =
    (TRIGGER_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

endpackage : logic_fault_pkg

// ---- rtl/logic_fault_status_inquiry.sv ----
// APB register bank reporting programmable logic fault flags
`timescale 1ns/1ps
`default_nettype none

module logic_fault_status_inquiry #(
  parameter int          ADDR_W          = 16,
  parameter logic [7:0]  IMPLEMENTED     = logic_fault_pkg::AVAIL_PRESENT,
  parameter int          MIN_LINE        = logic_fault_pkg::MIN_LINE_CYCLES,
  parameter int          TRIGGER_TIMEOUT = logic_fault_pkg::TRIGGER_TIMEOUT_CYCLES,
  parameter int          CNT_W           = 24
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              firmware_absent,
  input  wire logic              firmware_load_failed,
  input  wire logic              external_line_trigger,
  output logic                   line_trigger_accepted,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = ADDR_W'(logic_fault_pkg::BLOCK_BASE + {idx[13:0], 2'b00});
  endfunction

  wire logic hit_avail  = (paddr == reg_addr(logic_fault_pkg::IDX_AVAILABILITY));
  wire logic hit_flags  = (paddr == reg_addr(logic_fault_pkg::IDX_ERROR_FLAGS));
  wire logic hit_ctrl   = (paddr == reg_addr(logic_fault_pkg::IDX_CONTROL));
  wire logic hit_status = (paddr == reg_addr(logic_fault_pkg::IDX_IRQ_STATUS));
  wire logic hit_mask   = (paddr == reg_addr(logic_fault_pkg::IDX_IRQ_MASK));
  wire logic hit_rw     = hit_ctrl | hit_mask;
  wire logic hit_any    = hit_avail | hit_flags | hit_ctrl | hit_status | hit_mask;
  wire logic setup      = psel & ~penable;
  wire logic access_done = psel & penable & pready;
  // Read-only targets refuse writes with an error
  wire logic bad_access = ~hit_any | (pwrite & ~hit_rw);
  wire logic do_write   = access_done & pwrite & ~pslverr & pstrb[0];
  wire logic status_read = access_done & ~pwrite & ~pslverr & hit_status;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       control;
  logic [7:0]       irq_mask;
  logic [7:0]       irq_status;
  logic [7:0]       error_flags;
  logic [7:0]       flags_d;
  logic             trig_d;
  logic [CNT_W-1:0] since_line;
  logic             rate_exceeded;
  logic             trigger_missing;

  wire logic prog_mode = control[logic_fault_pkg::CTRL_PROG_MODE];

  // ----------------------------------------------------------------
  // Trigger supervision
  // ----------------------------------------------------------------
  // Inputs are synchronous, so one delay flop is enough for edges
  wire logic trig_edge  = external_line_trigger & ~trig_d;
  wire logic too_fast   = (since_line < CNT_W'(MIN_LINE));
  // Counter saturates so a long idle cannot wrap into a false fast line
  wire logic cnt_top    = (since_line == {CNT_W{1'b1}});
  wire logic timed_out  = (since_line >= CNT_W'(TRIGGER_TIMEOUT));
  wire logic drop_trig  = trig_edge & too_fast & prog_mode;
  wire logic take_trig  = trig_edge & ~drop_trig;
  wire logic fast_line  = take_trig & too_fast;

  wire logic next_rate_exceeded =
    fast_line ? 1'b1 : (take_trig ? 1'b0 : rate_exceeded);
  wire logic next_trigger_missing =
    trig_edge ? 1'b0 : (timed_out ? 1'b1 : trigger_missing);

  // ----------------------------------------------------------------
  // Error flag field
  // ----------------------------------------------------------------
  logic [7:0] next_flags;
  always_comb
  begin
    next_flags = logic_fault_pkg::RESET_FLAGS;
    next_flags[logic_fault_pkg::FLAG_NO_FIRMWARE]   = firmware_absent;
    next_flags[logic_fault_pkg::FLAG_LOAD_FAILED]   =
      firmware_load_failed & ~firmware_absent;
    next_flags[logic_fault_pkg::FLAG_RATE_EXCEEDED] = rate_exceeded;
    next_flags[logic_fault_pkg::FLAG_NO_TRIGGER]    = trigger_missing;
    next_flags[logic_fault_pkg::FLAG_RESERVED_TOP]  = 1'b0;
  end

  // Rising flags raise sticky interrupt events; set wins over read clear
  wire logic [7:0] flag_rise = error_flags & ~flags_d;
  wire logic [7:0] next_irq_status =
    (irq_status & ~{8{status_read}}) | flag_rise;
  wire logic next_irq = |(next_irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero; pslverr tells the master why
  wire logic [7:0] read_byte =
    hit_avail  ? IMPLEMENTED :
    hit_flags  ? error_flags :
    hit_ctrl   ? control :
    hit_status ? irq_status :
    hit_mask   ? irq_mask : 8'h00;
  // Writes return zero so stale read data never reaches the bus
  wire logic [31:0] read_word =
    pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};

  // ----------------------------------------------------------------
  // APB response selection
  // ----------------------------------------------------------------
  // Answer is latched in setup, so the access phase never waits
  wire logic        next_pready  =
    setup ? 1'b1 : (access_done ? 1'b0 : pready);
  wire logic        next_pslverr =
    setup ? bad_access : (access_done ? 1'b0 : pslverr);
  wire logic [31:0] next_prdata  =
    setup ? read_word : prdata;

  // ----------------------------------------------------------------
  // APB response registers
  // ----------------------------------------------------------------
  // Read data keeps its value after the transfer; only the flags drop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Software register selection
  // ----------------------------------------------------------------
  wire logic       write_ctrl    = do_write & hit_ctrl;
  wire logic       write_mask    = do_write & hit_mask;
  // Unused bits stay zero so read-back shows only live controls
  wire logic [7:0] next_control  =
    write_ctrl ? {7'h00, pwdata[logic_fault_pkg::CTRL_PROG_MODE]} : control;
  wire logic [7:0] next_irq_mask =
    write_mask ? {4'h0, pwdata[logic_fault_pkg::NUM_FLAGS-1:0]} : irq_mask;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control <= logic_fault_pkg::RESET_CONTROL;
    end
    else
    begin
      control <= next_control;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= logic_fault_pkg::RESET_IRQ_MASK;
    end
    else
    begin
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  // Flag field is live; reads never touch it, only irq_status clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_flags <= logic_fault_pkg::RESET_FLAGS;
    end
    else
    begin
      error_flags <= next_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_d <= logic_fault_pkg::RESET_FLAGS;
    end
    else
    begin
      flags_d <= error_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 8'h00;
    end
    else
    begin
      irq_status <= next_irq_status;
    end
  end

  // Built from the next status, so irq tracks it with no extra lag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Line timing
  // ----------------------------------------------------------------
  // Only accepted triggers restart the count; dropped ones do not
  wire logic [CNT_W-1:0] next_since_line =
    take_trig ? {CNT_W{1'b0}} : (cnt_top ? since_line : since_line + CNT_W'(1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_d <= 1'b0;
    end
    else
    begin
      trig_d <= external_line_trigger;
    end
  end

  // Reset saturated so the first trigger is never too fast
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      since_line <= {CNT_W{1'b1}};
    end
    else
    begin
      since_line <= next_since_line;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_exceeded <= 1'b0;
    end
    else
    begin
      rate_exceeded <= next_rate_exceeded;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger_missing <= 1'b0;
    end
    else
    begin
      trigger_missing <= next_trigger_missing;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_trigger_accepted <= 1'b0;
    end
    else
    begin
      line_trigger_accepted <= take_trig;
    end
  end

endmodule // logic_fault_status_inquiry

`default_nettype wire

// ---- verification/logic_fault_properties.sv ----
// Port-level properties of the logic fault status inquiry block
`timescale 1ns/1ps
`default_nettype none
module logic_fault_properties #(
  parameter int ADDR_W = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              firmware_absent,
  input wire logic              firmware_load_failed,
  input wire logic              external_line_trigger,
  input wire logic              line_trigger_accepted,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  a_ready_next: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_avail_value: assert property (setup && !pwrite && paddr == 16'h0C10 |=>
    prdata == 32'h01 && !pslverr) else $error("availability wrong");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:4] == 28'h0)
    else $error("bits above flags set");
  a_fw_flags: assert property (setup && !pwrite && paddr == 16'h0C14 && $past(presetn)
    && $stable(firmware_absent) && $stable(firmware_load_failed) |=> prdata[1:0] ==
    {$past(firmware_load_failed) & ~$past(firmware_absent), $past(firmware_absent)})
    else $error("firmware flags wrong");
  a_ro_refused: assert property (setup && pwrite && paddr == 16'h0C14 |=> pslverr)
    else $error("read-only write accepted");
  a_unmapped_err: assert property (setup && paddr == 16'h0C24 |=> pslverr)
    else $error("unmapped access accepted");
  a_accept_edge: assert property (line_trigger_accepted |->
    $past(external_line_trigger) && !$past(external_line_trigger, 2))
    else $error("accept without trigger edge");
  a_accept_pulse: assert property (line_trigger_accepted |=> !line_trigger_accepted)
    else $error("accept pulse too long");
  c_accept: cover property (line_trigger_accepted);
  c_irq: cover property (irq);
  c_err: cover property (pready && pslverr);
endmodule // logic_fault_properties
bind logic_fault_status_inquiry logic_fault_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .firmware_absent(firmware_absent), .irq(irq),
  .firmware_load_failed(firmware_load_failed), .external_line_trigger(external_line_trigger),
  .line_trigger_accepted(line_trigger_accepted));
`default_nettype wire

// ---- verification/logic_fault_status_inquiry_tb.sv ----
// Self-checking bench for the logic fault status inquiry block
`timescale 1ns/1ps
`default_nettype none
module logic_fault_status_inquiry_tb;
  localparam int ML = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic        firmware_absent, firmware_load_failed, external_line_trigger, line_trigger_accepted;
  logic [15:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          errors, n_tests, acc, a0, seed;
  // Short counts keep the run brief
  logic_fault_status_inquiry #(.MIN_LINE(ML), .TRIGGER_TIMEOUT(50)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .firmware_absent(firmware_absent), .irq(irq),
    .firmware_load_failed(firmware_load_failed), .external_line_trigger(external_line_trigger),
    .line_trigger_accepted(line_trigger_accepted));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (line_trigger_accepted === 1'b1) acc++;
  function automatic logic [31:0] fw_exp(input logic a, input logic f);
    return {30'h0, f & ~a, a};
  endfunction
  task automatic results;
    $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic pulse(input int gap);
    repeat (gap) @(posedge pclk);
    external_line_trigger <= 1'b1;
    @(posedge pclk);
    external_line_trigger <= 1'b0;
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {firmware_absent, firmware_load_failed, external_line_trigger} = '0;
    pstrb = 4'hF;
    seed = 32'h8A2A;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(16'h0C10, 32'h01, 32'hFFFF_FFFF);
    apb(1'b1, 16'h0C14, 32'hFF);
    chk(err, 32'h1);
    apb(1'b0, 16'h0C24, 32'h0);
    chk(err, 32'h1);
    $display("Test map done");
    for (int i = 0; i < 8; i++)
    begin
      firmware_absent <= (i == 0) || 1'($random(seed));
      firmware_load_failed <= (i == 0) || 1'($random(seed));
      repeat (2) @(posedge pclk);
      rdchk(16'h0C14, fw_exp(firmware_absent, firmware_load_failed), 32'hF3);
      rdchk(16'h0C14, fw_exp(firmware_absent, firmware_load_failed), 32'hF3);
    end
    firmware_absent <= 1'b0;
    firmware_load_failed <= 1'b0;
    $display("Test firmware done");
    apb(1'b1, 16'h0C18, 32'h0);
    a0 = acc;
    pulse(2 * ML);
    pulse(2 * ML);
    pulse(3);
    repeat (4) @(posedge pclk);
    rdchk(16'h0C14, 32'h4, 32'h4);
    chk(32'(acc - a0), 32'h3);
    pulse(2 * ML);
    repeat (4) @(posedge pclk);
    rdchk(16'h0C14, 32'h0, 32'h4);
    apb(1'b1, 16'h0C18, 32'h1);
    rdchk(16'h0C18, 32'h1, 32'hFF);
    a0 = acc;
    pulse(2 * ML);
    pulse(3);
    repeat (4) @(posedge pclk);
    rdchk(16'h0C14, 32'h0, 32'h4);
    chk(32'(acc - a0), 32'h1);
    $display("Test rate done");
    repeat (60) @(posedge pclk);
    rdchk(16'h0C14, 32'h8, 32'h8);
    pulse(1);
    repeat (4) @(posedge pclk);
    rdchk(16'h0C14, 32'h0, 32'h8);
    $display("Test trigger missing done");
    apb(1'b1, 16'h0C18, 32'h0);
    apb(1'b1, 16'h0C20, 32'h0);
    apb(1'b0, 16'h0C1C, 32'h0);
    pulse(2 * ML);
    pulse(3);
    repeat (4) @(posedge pclk);
    chk(irq, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, 16'h0C20, 32'hF);
    pstrb <= 4'hF;
    rdchk(16'h0C20, 32'h0, 32'hFF);
    apb(1'b1, 16'h0C20, 32'h4);
    rdchk(16'h0C20, 32'h4, 32'hFF);
    chk(irq, 32'h1);
    rdchk(16'h0C1C, 32'h4, 32'h4);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h0);
    $display("Test irq done");
    results();
  end
  // Whole run needs about 330 cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    results();
  end
endmodule // logic_fault_status_inquiry_tb
`default_nettype wire
